// ===== logic/dtm_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module dtm_ctrl
#(
    parameter int COMMIT_CYCLES = dtm_pkg::COMMIT_CYCLES
)
(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic [15:0]       io_addr_in,
    input  wire logic              io_wr_in,
    input  wire logic [7:0]        io_wdata_in,
    output logic      [7:0]        io_rdata_out,
    input  wire logic [1:0]        power_mode_in,
    input  wire logic              sec_tick_in,
    input  wire logic              sense_done_in,
    input  wire logic [10:0]       sense_thermal_in,
    input  wire logic [7:0]        sense_battery_in,
    output logic                   sense_temp_run_out,
    output logic                   sense_batt_run_out,
    output logic                   osc_run_out,
    output logic [1:0]             osc_test_out,
    output logic                   supply_main_out,
    output logic                   battery_main_out,
    output logic                   battery_load_out
);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // ----------------------------------------------------------------
    // Sensor input synchronisers
    // ----------------------------------------------------------------
    dtm_pkg::dtm_sense_t sense_raw;
    dtm_pkg::dtm_sense_t sense_s1_q;
    dtm_pkg::dtm_sense_t sense_s2_q;
    logic                done_prev_q;
    logic                done_rise;

    assign sense_raw = '{done: sense_done_in, thermal: sense_thermal_in, battery: sense_battery_in};

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sense_s1_q  <= '0;
            sense_s2_q  <= '0;
            done_prev_q <= 1'b0;
        end
        else
        begin
            sense_s1_q  <= sense_raw;
            sense_s2_q  <= sense_s1_q;
            done_prev_q <= sense_s2_q.done;
        end
    end

    assign done_rise = sense_s2_q.done & ~done_prev_q;

    // ----------------------------------------------------------------
    // Mode decode and register writes
    // ----------------------------------------------------------------
    dtm_pkg::dtm_mode_t  mode;
    dtm_pkg::dtm_state_t state_q;
    dtm_pkg::dtm_state_t state_d;
    dtm_pkg::dtm_cfg_t   cfg_q;
    dtm_pkg::dtm_cfg_t   cfg_pend_q;
    logic                asleep;
    logic                busy_q;
    logic [31:0]         busy_cnt_q;
    logic                wr_cfg;
    logic                wr_trig;
    logic                trig_q;
    logic                meas_end;
    logic [1:0]          test_q;
    logic                load_q;

    assign mode     = dtm_pkg::dtm_mode_t'(power_mode_in);
    assign asleep   = (mode == dtm_pkg::DTM_MODE_SLEEP) || (mode == dtm_pkg::DTM_MODE_DISPLAY);
    assign wr_cfg   = io_wr_in && (io_addr_in == dtm_pkg::ADDR_CFG) && !busy_q;
    assign wr_trig  = io_wr_in && (io_addr_in == dtm_pkg::ADDR_TRIG) && io_wdata_in[dtm_pkg::BIT_TRIG]
                      && (cfg_q.sense_interval_select == dtm_pkg::PER_MANUAL) && !asleep;
    assign meas_end = done_rise && ((state_q == dtm_pkg::DTM_BATT) ||
                      ((state_q == dtm_pkg::DTM_TEMP) && !cfg_q.battery_measure_enable));

    // Commit of the configuration byte takes the full busy window, then lands
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cfg_q      <= dtm_pkg::CFG_RST;
            cfg_pend_q <= dtm_pkg::CFG_RST;
            busy_q     <= 1'b0;
            busy_cnt_q <= '0;
        end
        else if (wr_cfg)
        begin
            cfg_pend_q <= dtm_pkg::dtm_cfg_t'(io_wdata_in);
            busy_q     <= 1'b1;
            busy_cnt_q <= '0;
        end
        else if (busy_q)
        begin
            busy_cnt_q <= busy_cnt_q + 32'h00000001;
            if (busy_cnt_q == 32'(COMMIT_CYCLES - 1))
            begin
                busy_q <= 1'b0;
                cfg_q  <= cfg_pend_q;
            end
        end
    end

    // Set wins over the completion clear
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            trig_q <= 1'b0;
        else if (wr_trig)
            trig_q <= 1'b1;
        else if (meas_end)
            trig_q <= 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            test_q <= dtm_pkg::TEST_RST;
            load_q <= 1'b0;
        end
        else if (io_wr_in && io_addr_in == dtm_pkg::ADDR_TEST)
        begin
            test_q <= io_wdata_in[1:0];
        end
        else if (io_wr_in && io_addr_in == dtm_pkg::ADDR_LOAD)
        begin
            load_q <= io_wdata_in[dtm_pkg::BIT_LOAD];
        end
    end

    // ----------------------------------------------------------------
    // Interval timer on the always-on second tick
    // ----------------------------------------------------------------
    logic [9:0] sec_cnt_q;
    logic [9:0] period_m1;
    logic       auto_pend_q;
    logic       periodic;

    assign periodic  = (cfg_q.sense_interval_select != dtm_pkg::PER_MANUAL) &&
                       (cfg_q.sense_interval_select != dtm_pkg::PER_CONT);
    assign period_m1 = 10'((11'h001 << (dtm_pkg::PER_EXP_BASE + 4'(cfg_q.sense_interval_select))) - 11'h001);

    always_ff @(posedge clk_in)
    begin
        if (rst_in || !periodic)
        begin
            sec_cnt_q   <= '0;
            auto_pend_q <= 1'b0;
        end
        else if (sec_tick_in && sec_cnt_q == period_m1)
        begin
            sec_cnt_q   <= '0;
            auto_pend_q <= 1'b1;
        end
        else
        begin
            if (sec_tick_in)
            begin
                sec_cnt_q <= sec_cnt_q + 10'h001;
            end
            if (state_q == dtm_pkg::DTM_IDLE)
            begin
                auto_pend_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Measurement sequencer
    // ----------------------------------------------------------------
    logic start_req;

    // Any power mode: the sequencer needs no processor activity
    assign start_req = trig_q || auto_pend_q ||
                       (cfg_q.sense_interval_select == dtm_pkg::PER_CONT);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            dtm_pkg::DTM_IDLE:
                if (start_req)
                    state_d = dtm_pkg::DTM_TEMP;
            dtm_pkg::DTM_TEMP:
                if (done_rise)
                    state_d = cfg_q.battery_measure_enable ? dtm_pkg::DTM_BATT : dtm_pkg::DTM_IDLE;
            dtm_pkg::DTM_BATT:
                if (done_rise)
                    state_d = dtm_pkg::DTM_IDLE;
            default:
                state_d = dtm_pkg::DTM_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            state_q <= dtm_pkg::DTM_IDLE;
        else
            state_q <= state_d;
    end

    // ----------------------------------------------------------------
    // Results
    // ----------------------------------------------------------------
    logic [10:0] thermal_q;
    logic [7:0]  battery_q;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            thermal_q <= '0;
            battery_q <= '0;
        end
        else if (done_rise && state_q == dtm_pkg::DTM_TEMP)
            thermal_q <= sense_s2_q.thermal;
        else if (done_rise && state_q == dtm_pkg::DTM_BATT)
            battery_q <= sense_s2_q.battery;
    end

    // ----------------------------------------------------------------
    // Read data and analog controls
    // ----------------------------------------------------------------
    logic [7:0] rdata_d;

    always_comb
    begin
        rdata_d = 8'h00;
        unique case (io_addr_in)
            dtm_pkg::ADDR_RES_HI: rdata_d = thermal_q[10:3];
            dtm_pkg::ADDR_RES_LO: rdata_d = {thermal_q[2:0], 5'h00};
            dtm_pkg::ADDR_BATT:   rdata_d = battery_q;
            dtm_pkg::ADDR_CFG:    rdata_d = {cfg_q[7:4], busy_q, cfg_q.sense_interval_select};
            dtm_pkg::ADDR_TRIG:   rdata_d = {1'b0, trig_q, 6'h00};
            dtm_pkg::ADDR_TEST:   rdata_d = {6'h00, test_q};
            dtm_pkg::ADDR_LOAD:   rdata_d = {4'h0, load_q, 3'h0};
            default:              rdata_d = 8'h00;
        endcase
    end

    // Main supply and load decisions follow the mode each cycle, not the write
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            io_rdata_out       <= 8'h00;
            sense_temp_run_out <= 1'b0;
            sense_batt_run_out <= 1'b0;
            osc_run_out        <= 1'b0;
            osc_test_out       <= dtm_pkg::TEST_RST;
            supply_main_out    <= 1'b0;
            battery_main_out   <= 1'b0;
            battery_load_out   <= 1'b0;
        end
        else
        begin
            io_rdata_out       <= rdata_d;
            sense_temp_run_out <= (state_d == dtm_pkg::DTM_TEMP);
            sense_batt_run_out <= (state_d == dtm_pkg::DTM_BATT);
            osc_run_out        <= (state_d != dtm_pkg::DTM_IDLE) || (test_q != dtm_pkg::TEST_NORMAL);
            osc_test_out       <= test_q;
            supply_main_out    <= cfg_q.sensor_supply_select && !asleep;
            battery_main_out   <= cfg_q.battery_source_select;
            battery_load_out   <= load_q && (mode == dtm_pkg::DTM_MODE_MISSION);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_manual_start: assert property (wr_trig && state_q == dtm_pkg::DTM_IDLE |=> ##1 sense_temp_run_out)
        else $error("trigger did not start a measurement");
    a_trig_ignored: assert property (io_wr_in && io_addr_in == dtm_pkg::ADDR_TRIG && asleep && !trig_q
        |=> !trig_q)
        else $error("trigger accepted while asleep");
    a_trig_clear: assert property (meas_end && !wr_trig |=> !trig_q)
        else $error("trigger not cleared at completion");
    a_busy_lock: assert property (busy_q && io_wr_in && io_addr_in == dtm_pkg::ADDR_CFG
        |=> $stable(cfg_pend_q) && busy_q || $past(busy_cnt_q) == 32'(COMMIT_CYCLES - 1))
        else $error("config write taken while busy");
    a_busy_set: assert property (wr_cfg |=> busy_q && $stable(cfg_q))
        else $error("busy not raised on config write");
    a_batt_phase: assert property (done_rise && state_q == dtm_pkg::DTM_TEMP && cfg_q.battery_measure_enable
        |=> state_q == dtm_pkg::DTM_BATT ##0 sense_batt_run_out)
        else $error("battery phase skipped");
    a_result_take: assert property (done_rise && state_q == dtm_pkg::DTM_TEMP
        |=> thermal_q == $past(sense_s2_q.thermal))
        else $error("result not captured");
    a_sleep_supply: assert property (asleep |=> !supply_main_out)
        else $error("main supply used while asleep");
    a_load_gate: assert property (battery_load_out |-> $past(mode) == dtm_pkg::DTM_MODE_MISSION && $past(load_q))
        else $error("battery load outside mission mode");
    a_cont_run: assert property (cfg_q.sense_interval_select == dtm_pkg::PER_CONT && state_q == dtm_pkg::DTM_IDLE
        |=> state_q == dtm_pkg::DTM_TEMP)
        else $error("continuous mode stalled");
    a_test_osc: assert property (test_q != dtm_pkg::TEST_NORMAL |=> osc_run_out)
        else $error("oscillator not forced by test field");

    c_manual: cover property (wr_trig ##[1:50] meas_end);
    c_auto: cover property (auto_pend_q && asleep ##1 state_q == dtm_pkg::DTM_TEMP);
    c_batt: cover property (state_q == dtm_pkg::DTM_BATT && done_rise);

endmodule

`default_nettype wire

// ===== common/dtm_pkg.sv
`default_nettype none

package dtm_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] ADDR_TEST    = 16'h2500;
    localparam logic [15:0] ADDR_LOAD    = 16'h2704;
    localparam logic [15:0] ADDR_RES_HI  = 16'h2881;
    localparam logic [15:0] ADDR_RES_LO  = 16'h2882;
    localparam logic [15:0] ADDR_BATT    = 16'h2885;
    localparam logic [15:0] ADDR_CFG     = 16'h28A0;
    localparam logic [15:0] ADDR_TRIG    = 16'h28B4;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int          BIT_LOAD     = 3;
    localparam int          BIT_TRIG     = 6;
    localparam int          BIT_BUSY     = 3;
    localparam logic [2:0]  PER_MANUAL   = 3'h0;
    localparam logic [2:0]  PER_CONT     = 3'h7;
    localparam logic [3:0]  PER_EXP_BASE = 4'h3;
    localparam logic [1:0]  TEST_RST     = 2'h0;
    localparam logic [1:0]  TEST_NORMAL  = 2'h0;

    // ----------------------------------------------------------------
    // Timing: configuration byte commit time
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_PS  = 4000;
    localparam longint      COMMIT_TIME_NS = 6000000;
    localparam int          COMMIT_CYCLES  = int'((COMMIT_TIME_NS * 1000) / CLK_PERIOD_PS);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        DTM_MODE_MISSION  = 2'h0,
        DTM_MODE_BROWNOUT = 2'h1,
        DTM_MODE_DISPLAY  = 2'h2,
        DTM_MODE_SLEEP    = 2'h3
    } dtm_mode_t;

    typedef enum logic [2:0]
    {
        DTM_IDLE = 3'b001,
        DTM_TEMP = 3'b010,
        DTM_BATT = 3'b100
    } dtm_state_t;

    // Configuration byte layout, msb first
    typedef struct packed
    {
        logic       battery_source_select;
        logic       sensor_supply_select;
        logic       comp_enable;
        logic       battery_measure_enable;
        logic       busy_slot;
        logic [2:0] sense_interval_select;
    } dtm_cfg_t;

    localparam dtm_cfg_t CFG_RST = '0;

    // Sensor answer carried across from the analog side
    typedef struct packed
    {
        logic        done;
        logic [10:0] thermal;
        logic [7:0]  battery;
    } dtm_sense_t;

endpackage

`default_nettype wire

// ===== sim/dtm_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none

module dtm_ctrl_tb;

    localparam int COMMIT = 20;

    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [15:0] io_addr_in = 16'h0000;
    logic        io_wr_in = 1'b0;
    logic [7:0]  io_wdata_in = 8'h00;
    logic [7:0]  io_rdata_out;
    logic [1:0]  power_mode_in = 2'h0;
    logic        sec_tick_in = 1'b0;
    logic        sense_done_in = 1'b0;
    logic [10:0] sense_thermal_in = 11'h000;
    logic [7:0]  sense_battery_in = 8'h00;
    logic        sense_temp_run_out;
    logic        sense_batt_run_out;
    logic        osc_run_out;
    logic [1:0]  osc_test_out;
    logic        supply_main_out;
    logic        battery_main_out;
    logic        battery_load_out;
    int          n_fail = 0;
    int          samples_checked = 0;
    logic [7:0]  d;
    int          model_q [$];
    logic [15:0] reset_addr [8] = '{dtm_pkg::ADDR_TEST, dtm_pkg::ADDR_LOAD, dtm_pkg::ADDR_CFG, dtm_pkg::ADDR_TRIG,
                                    dtm_pkg::ADDR_RES_HI, dtm_pkg::ADDR_RES_LO, dtm_pkg::ADDR_BATT, 16'h2600};

    dtm_ctrl #(.COMMIT_CYCLES(COMMIT)) i_dtm_ctrl
    (
        .clk_in             (clk_in),
        .rst_in             (rst_in),
        .io_addr_in         (io_addr_in),
        .io_wr_in           (io_wr_in),
        .io_wdata_in        (io_wdata_in),
        .io_rdata_out       (io_rdata_out),
        .power_mode_in      (power_mode_in),
        .sec_tick_in        (sec_tick_in),
        .sense_done_in      (sense_done_in),
        .sense_thermal_in   (sense_thermal_in),
        .sense_battery_in   (sense_battery_in),
        .sense_temp_run_out (sense_temp_run_out),
        .sense_batt_run_out (sense_batt_run_out),
        .osc_run_out        (osc_run_out),
        .osc_test_out       (osc_test_out),
        .supply_main_out    (supply_main_out),
        .battery_main_out   (battery_main_out),
        .battery_load_out   (battery_load_out)
    );

    always #2 clk_in = ~clk_in;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            n_fail++;
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_in);
        io_addr_in  <= a;
        io_wdata_in <= v;
        io_wr_in    <= 1'b1;
        @(posedge clk_in);
        io_wr_in    <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk_in);
        io_addr_in <= a;
        @(posedge clk_in);
        #1 v = io_rdata_out;
    endtask

    // Config writes must wait out the commit window before the next one
    task automatic cfg_wr(input logic [7:0] v);
        wr(dtm_pkg::ADDR_CFG, v);
        repeat (COMMIT + 4) @(posedge clk_in);
    endtask

    // One sensor phase: wait for run, present value, pulse done
    task automatic phase(input bit bat, input int v);
        int k;
        k = 0;
        while ((bat ? sense_batt_run_out : sense_temp_run_out) !== 1'b1 && k < 40)
        begin
            @(posedge clk_in);
            #1 k++;
        end
        chk("run_start", 16'(k < 40), 16'h1);
        @(posedge clk_in);
        if (bat)
            sense_battery_in <= v[7:0];
        else
            sense_thermal_in <= v[10:0];
        model_q.push_back(v);
        @(posedge clk_in);
        sense_done_in <= 1'b1;
        k = 0;
        while ((bat ? sense_batt_run_out : sense_temp_run_out) !== 1'b0 && k < 20)
        begin
            @(posedge clk_in);
            #1 k++;
        end
        chk("run_end", 16'(k < 20), 16'h1);
        @(posedge clk_in);
        sense_done_in <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask

    // Full measurement; the model holds the expected codes as integers
    task automatic measure(input bit bat, input int t);
        int b;
        logic [7:0] v;
        b = $urandom_range(255);
        phase(0, t);
        if (bat)
            phase(1, b);
        else
            #1 chk("batt_run", 16'(sense_batt_run_out), 16'h0);
        t = model_q.pop_front();
        rd(dtm_pkg::ADDR_RES_HI, v);
        chk("result_hi", 16'(v), 16'((t >> 3) & 255));
        rd(dtm_pkg::ADDR_RES_LO, v);
        chk("result_lo", 16'(v & 8'hE0), 16'((t & 7) << 5));
        if (bat)
        begin
            rd(dtm_pkg::ADDR_BATT, v);
            chk("battery", 16'(v), 16'(model_q.pop_front()));
        end
    endtask

    task automatic manual(input bit bat, input int t);
        wr(dtm_pkg::ADDR_TRIG, 8'h40);
        rd(dtm_pkg::ADDR_TRIG, d);
        chk("trig_set", 16'(d & 8'h40), 16'h40);
        measure(bat, t);
        rd(dtm_pkg::ADDR_TRIG, d);
        chk("trig_clr", 16'(d & 8'h40), 16'h0);
    endtask

    task automatic tick();
        @(posedge clk_in);
        sec_tick_in <= 1'b1;
        @(posedge clk_in);
        sec_tick_in <= 1'b0;
    endtask

    // Interval code n needs 2^(3+n) ticks; only the last one may start the run
    task automatic auto_run(input int per, input bit bat);
        repeat ((1 << (3 + per)) - 1) tick();
        repeat (3) @(posedge clk_in);
        #1 chk("early", 16'(sense_temp_run_out), 16'h0);
        tick();
        measure(bat, $urandom_range(2047));
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h890b));
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        foreach (reset_addr[i])
        begin
            rd(reset_addr[i], d);
            chk("reset_reg", 16'(d), 16'h0);
        end
        chk("reset_outs", 16'({osc_run_out, supply_main_out, battery_main_out, battery_load_out,
                               sense_temp_run_out, sense_batt_run_out, osc_test_out}), 16'h0);
        // Every test code, including the reserved ones
        for (int m = 0; m < 4; m++)
        begin
            wr(dtm_pkg::ADDR_TEST, 8'(m));
            repeat (2) @(posedge clk_in);
            #1 chk("osc_test", 16'(osc_test_out), 16'(m));
            chk("osc_run", 16'(osc_run_out), 16'(m != 0));
        end
        wr(dtm_pkg::ADDR_TEST, 8'h00);
        // Load only reaches the battery in mission mode
        wr(dtm_pkg::ADDR_LOAD, 8'h08);
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk_in);
            power_mode_in <= 2'(m);
            repeat (3) @(posedge clk_in);
            #1 chk("load", 16'(battery_load_out), 16'(m == 0));
        end
        @(posedge clk_in);
        power_mode_in <= dtm_pkg::DTM_MODE_MISSION;
        wr(dtm_pkg::ADDR_LOAD, 8'h00);
        manual(0, 1024);
        manual(0, 1023);
        // A run stuck on a flat backup battery is finished from the main supply
        wr(dtm_pkg::ADDR_TRIG, 8'h40);
        cfg_wr(8'h40);
        #1 chk("rescue_supply", 16'(supply_main_out), 16'h1);
        measure(0, $urandom_range(2047));
        // Second write during commit must be locked out
        wr(dtm_pkg::ADDR_CFG, 8'hD0);
        rd(dtm_pkg::ADDR_CFG, d);
        chk("busy", 16'(d & 8'h08), 16'h08);
        wr(dtm_pkg::ADDR_CFG, 8'h00);
        repeat (COMMIT + 4) @(posedge clk_in);
        rd(dtm_pkg::ADDR_CFG, d);
        chk("cfg", 16'(d), 16'hD0);
        chk("batt_sel", 16'(battery_main_out), 16'h1);
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk_in);
            power_mode_in <= 2'(m);
            repeat (3) @(posedge clk_in);
            #1 chk("supply", 16'(supply_main_out), 16'(m < 2));
            wr(dtm_pkg::ADDR_TRIG, 8'h40);
            rd(dtm_pkg::ADDR_TRIG, d);
            if (m < 2)
                measure(1, $urandom_range(2047));
            else
                chk("trig_asleep", 16'(d), 16'h0);
        end
        @(posedge clk_in);
        power_mode_in <= dtm_pkg::DTM_MODE_MISSION;
        cfg_wr(8'hD1);
        wr(dtm_pkg::ADDR_TRIG, 8'h40);
        rd(dtm_pkg::ADDR_TRIG, d);
        chk("trig_periodic", 16'(d), 16'h0);
        chk("no_run", 16'(sense_temp_run_out), 16'h0);
        @(posedge clk_in);
        power_mode_in <= dtm_pkg::DTM_MODE_SLEEP;
        // Interval code 1 gives a period of sixteen ticks, code 2 of thirty-two
        auto_run(1, 1);
        auto_run(1, 1);
        cfg_wr(8'hC2);
        power_mode_in <= dtm_pkg::DTM_MODE_DISPLAY;
        auto_run(2, 0);
        @(posedge clk_in);
        power_mode_in <= dtm_pkg::DTM_MODE_MISSION;
        cfg_wr(8'h07);
        #1 chk("batt_sel_rtc", 16'(battery_main_out), 16'h0);
        measure(0, $urandom_range(2047));
        measure(0, $urandom_range(2047));
        test_done();
    end

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    initial
    begin
        #(4 * 30000);
        n_fail++;
        test_done();
    end

endmodule

`default_nettype wire
